// ---- src/aec_pkg.sv ----
// constants, field layouts and carrier types of the event counter block
package aec_pkg;

   // ************************************************************
   // register indices and byte addresses
   // ************************************************************
   localparam logic [15:0] AEC_IDX_CTRL  = 16'hff95;
   localparam logic [15:0] AEC_IDX_HIGH  = 16'hff96;
   localparam logic [15:0] AEC_IDX_LOW   = 16'hff97;
   localparam logic [15:0] AEC_IDX_CKSTP = 16'hfffb;
   localparam int          AEC_AW        = 18;
   localparam logic [AEC_AW-1:0] AEC_ADDR_CTRL  = {AEC_IDX_CTRL, 2'b00};
   localparam logic [AEC_AW-1:0] AEC_ADDR_HIGH  = {AEC_IDX_HIGH, 2'b00};
   localparam logic [AEC_AW-1:0] AEC_ADDR_LOW   = {AEC_IDX_LOW, 2'b00};
   localparam logic [AEC_AW-1:0] AEC_ADDR_CKSTP = {AEC_IDX_CKSTP, 2'b00};

   // ************************************************************
   // reset values and counter constants
   // ************************************************************
   localparam logic [7:0]  AEC_CTRL_RST    = 8'h00;
   localparam logic [3:0]  AEC_CKSTP_RST   = 4'hf;
   localparam logic [3:0]  AEC_CKSTP_UPPER = 4'hf;
   localparam int          AEC_STANDBY_BIT = 3;
   localparam logic [7:0]  AEC_CNT_RST     = 8'h00;
   localparam logic [7:0]  AEC_CNT_MAX     = 8'hff;
   localparam logic [7:0]  AEC_CNT_ONE     = 8'h01;
   localparam logic [23:0] AEC_RD_PAD      = 24'h00_0000;
   localparam logic [31:0] AEC_RD_NONE     = 32'h0000_0000;

   // ************************************************************
   // types
   // ************************************************************
   // control/status layout, bit 7 first
   typedef struct packed {
      logic overflow_flag_high;
      logic overflow_flag_low;
      logic rsv;
      logic ch2;
      logic count_enable_high;
      logic count_enable_low;
      logic count_reset_ctrl_high;
      logic count_reset_ctrl_low;
   } aec_ctrl_t;

   typedef enum logic [0:0] {AEC_BUS_IDLE, AEC_BUS_ANSWER} aec_bus_t;

   typedef enum logic [2:0] {
      AEC_SEL_NONE, AEC_SEL_CTRL, AEC_SEL_HIGH, AEC_SEL_LOW, AEC_SEL_CKSTP
   } aec_sel_t;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [AEC_AW-1:0] address;
      logic [3:0]        byteenable;
      logic [31:0]       writedata;
   } aec_av_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } aec_av_rsp_t;

   typedef struct packed {
      aec_bus_t    phase;
      logic        pin_h_q;
      logic        pin_l_q;
      logic [7:0]  cnt_h;
      logic [7:0]  cnt_l;
      aec_ctrl_t   ctrl;
      logic [3:0]  ckstp;
      logic        arm_h;
      logic        arm_l;
      logic        irq_flag;
      logic [31:0] rdata;
   } aec_state_t;

   localparam aec_state_t AEC_STATE_RST = '{
      phase:    AEC_BUS_IDLE,
      pin_h_q:  1'b0,
      pin_l_q:  1'b0,
      cnt_h:    AEC_CNT_RST,
      cnt_l:    AEC_CNT_RST,
      ctrl:     AEC_CTRL_RST,
      ckstp:    AEC_CKSTP_RST,
      arm_h:    1'b0,
      arm_l:    1'b0,
      irq_flag: 1'b0,
      rdata:    AEC_RD_NONE
   };

endpackage

// ---- src/aec_async_event_counter.sv ----
// event counter pair with control/status, standby and avalon slave
//
// Notes on behaviour
// - chained counters act as one 16-bit up-counter wrapping after 65536 events
// - counting runs on event edges sampled on the system clock, so it needs that clock running
// - a high overflow, or a low one in split mode, sets the request flag; irq_o also needs irq_enable_i
// - control/status register is eight bits, all zero after reset
// - bit 7 high flag sets when the high counter wraps to zero
// - software only clears flags: read one, then write zero; one ignored
// - when chained the high flag marks the 16-bit wrap
// - bit 6 low flag sets on low wrap only in split mode
// - bit 5 is plain storage, reset to zero
// - split select zero: low counts low pin, high counts low overflow
// - split select one: each counter counts its own pin
// - bit 3 gates high counter events; zero holds it
// - bit 2 gates low counter events; zero holds it
// - bit 1 zero keeps high counter cleared; one lets it count
// - bit 0 zero keeps low counter cleared; one lets it count
// - control, high, low at consecutive places; counters read-only, reset zero
// - block has a software selected standby state
// - clock-stop bit 3 zero means standby; resets to one
// - after overflow a counter wraps to zero and keeps counting
// - a high overflow, or a low one in split mode, sets the request flag; signalled only while enabled
//
// usage
// registers sit at index times four on an 18-bit byte address
// every access takes two cycles: taken, then answered
// pins are sampled on the system clock: each high and each low
// must last one clock at least, or an event is lost
// high and low counters are read apart, so a carry may fall
// between the two reads; read high, low, high and compare
// standby freezes counting; registers stay reachable
// flag clearing wants a read of one, then a write of zero
// the request flag clears through its own port, not the bus
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module aec_async_event_counter (
   input  wire logic                 clk_sys_i,
   input  wire logic                 rst_i,
   input  wire aec_pkg::aec_av_req_t av_req_i,
   output var  aec_pkg::aec_av_rsp_t av_rsp_o,
   input  wire logic                 event_pin_high_i,
   input  wire logic                 event_pin_low_i,
   input  wire logic                 irq_enable_i,
   input  wire logic                 irq_flag_clear_i,
   output logic                      irq_flag_o,
   output logic                      irq_o
);
   import aec_pkg::*;

   // ************************************************************
   // address decoding
   // ************************************************************
   function automatic aec_sel_t aec_decode(input logic [AEC_AW-1:0] addr);
      aec_sel_t sel;
      sel = AEC_SEL_NONE;
      if (addr == AEC_ADDR_CTRL) begin
         sel = AEC_SEL_CTRL;
      end else if (addr == AEC_ADDR_HIGH) begin
         sel = AEC_SEL_HIGH;
      end else if (addr == AEC_ADDR_LOW) begin
         sel = AEC_SEL_LOW;
      end else if (addr == AEC_ADDR_CKSTP) begin
         sel = AEC_SEL_CKSTP;
      end
      return sel;
   endfunction

   // ************************************************************
   // state and helper signals
   // ************************************************************
   aec_state_t s_r;
   aec_state_t s_nxt;
   aec_ctrl_t  wd_ctrl;
   aec_sel_t   rd_sel;
   aec_sel_t   wr_sel;
   logic       edge_h;
   logic       edge_l;
   logic       standby;
   logic       inc_l;
   logic       inc_h;
   logic       src_h;
   logic       ovf_l;
   logic       ovf_h;
   logic       ovl_set;
   logic       wr_ctrl;
   logic       wr_ckstp;
   logic       clr_h;
   logic       clr_l;
   logic       bus_acc;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_nxt   = s_r;
      bus_acc = av_req_i.read | av_req_i.write;
      rd_sel  = aec_decode(av_req_i.address);
      wr_sel  = aec_decode(av_req_i.address);
      wd_ctrl = aec_ctrl_t'(av_req_i.writedata[7:0]);

      // pins are sampled on the system clock, so a slow event source
      // needs highs and lows of at least one clock period each
      edge_h  = event_pin_high_i & ~s_r.pin_h_q;
      edge_l  = event_pin_low_i & ~s_r.pin_l_q;
      s_nxt.pin_h_q = event_pin_high_i;
      s_nxt.pin_l_q = event_pin_low_i;

      standby = ~s_r.ckstp[AEC_STANDBY_BIT];

      // low counter always takes the low pin
      inc_l = edge_l & s_r.ctrl.count_enable_low & s_r.ctrl.count_reset_ctrl_low & ~standby;
      ovf_l = inc_l & (s_r.cnt_l == AEC_CNT_MAX);

      // high source: own pin when split, low carry when chained
      src_h = s_r.ctrl.ch2 ? edge_h : ovf_l;
      inc_h = src_h & s_r.ctrl.count_enable_high & s_r.ctrl.count_reset_ctrl_high & ~standby;
      ovf_h = inc_h & (s_r.cnt_h == AEC_CNT_MAX);

      // counters hold in standby, clear while reset control is zero
      if (!standby) begin
         if (!s_r.ctrl.count_reset_ctrl_low) begin
            s_nxt.cnt_l = AEC_CNT_RST;
         end else if (inc_l) begin
            s_nxt.cnt_l = s_r.cnt_l + AEC_CNT_ONE;
         end
         if (!s_r.ctrl.count_reset_ctrl_high) begin
            s_nxt.cnt_h = AEC_CNT_RST;
         end else if (inc_h) begin
            s_nxt.cnt_h = s_r.cnt_h + AEC_CNT_ONE;
         end
      end

      // register writes take effect at the answering edge only
      wr_ctrl  = av_req_i.write & av_req_i.byteenable[0] &
                 (s_r.phase == AEC_BUS_ANSWER) & (wr_sel == AEC_SEL_CTRL);
      wr_ckstp = av_req_i.write & av_req_i.byteenable[0] &
                 (s_r.phase == AEC_BUS_ANSWER) & (wr_sel == AEC_SEL_CKSTP);

      // a zero clears only after the flag was read as one
      clr_h = wr_ctrl & ~wd_ctrl.overflow_flag_high & s_r.arm_h;
      clr_l = wr_ctrl & ~wd_ctrl.overflow_flag_low & s_r.arm_l;
      ovl_set = ovf_l & s_r.ctrl.ch2;

      // set beats clear in the same cycle
      s_nxt.ctrl.overflow_flag_high = ovf_h | (s_r.ctrl.overflow_flag_high & ~clr_h);
      s_nxt.ctrl.overflow_flag_low = ovl_set | (s_r.ctrl.overflow_flag_low & ~clr_l);

      if (wr_ctrl) begin
         s_nxt.ctrl.rsv  = wd_ctrl.rsv;
         s_nxt.ctrl.ch2  = wd_ctrl.ch2;
         s_nxt.ctrl.count_enable_high = wd_ctrl.count_enable_high;
         s_nxt.ctrl.count_enable_low = wd_ctrl.count_enable_low;
         s_nxt.ctrl.count_reset_ctrl_high = wd_ctrl.count_reset_ctrl_high;
         s_nxt.ctrl.count_reset_ctrl_low = wd_ctrl.count_reset_ctrl_low;
         s_nxt.arm_h     = 1'b0;
         s_nxt.arm_l     = 1'b0;
      end
      if (wr_ckstp) begin
         s_nxt.ckstp = av_req_i.writedata[3:0];
      end

      // request flag toward the interrupt controller, set wins
      s_nxt.irq_flag = ovf_h | ovl_set |
                       (s_r.irq_flag & ~irq_flag_clear_i);

      // bus phases: take the request, then answer one cycle later
      case (s_r.phase)
         AEC_BUS_IDLE: begin
            if (bus_acc) begin
               s_nxt.phase = AEC_BUS_ANSWER;
               s_nxt.rdata = AEC_RD_NONE;
               if (av_req_i.read) begin
                  // counters live in this domain, so a read is coherent
                  if (rd_sel == AEC_SEL_CTRL) begin
                     s_nxt.rdata = {AEC_RD_PAD, s_r.ctrl};
                     s_nxt.arm_h = s_r.ctrl.overflow_flag_high;
                     s_nxt.arm_l = s_r.ctrl.overflow_flag_low;
                  end else if (rd_sel == AEC_SEL_HIGH) begin
                     s_nxt.rdata = {AEC_RD_PAD, s_r.cnt_h};
                  end else if (rd_sel == AEC_SEL_LOW) begin
                     s_nxt.rdata = {AEC_RD_PAD, s_r.cnt_l};
                  end else if (rd_sel == AEC_SEL_CKSTP) begin
                     s_nxt.rdata = {AEC_RD_PAD, AEC_CKSTP_UPPER, s_r.ckstp};
                  end
               end
            end
         end
         AEC_BUS_ANSWER: begin
            s_nxt.phase = AEC_BUS_IDLE;
         end
         default: begin
            s_nxt.phase = AEC_BUS_IDLE;
         end
      endcase
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         s_r <= AEC_STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // waitrequest is combinational so every access costs two cycles
   always_comb begin
      av_rsp_o.readdata    = s_r.rdata;
      av_rsp_o.waitrequest = bus_acc & (s_r.phase == AEC_BUS_IDLE);
      irq_flag_o           = s_r.irq_flag;
      irq_o                = s_r.irq_flag & irq_enable_i;
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);

   a_high_flag_set: assert property (
      ovf_h |=> s_r.ctrl.overflow_flag_high && s_r.irq_flag)
      else $error("high overflow did not set its flag");

   a_chain_wrap: assert property (
      (!s_r.ctrl.ch2 && ovf_l && s_r.cnt_h == AEC_CNT_MAX && s_r.ctrl.count_enable_high
       && s_r.ctrl.count_reset_ctrl_high) |=> s_r.cnt_h == AEC_CNT_RST
       && s_r.cnt_l == AEC_CNT_RST && s_r.ctrl.overflow_flag_high)
      else $error("16-bit wrap not seen in chained mode");

   a_low_flag_mode: assert property (
      !s_r.ctrl.ch2 |=> !$rose(s_r.ctrl.overflow_flag_low))
      else $error("low flag rose while chained");

   a_flag_no_soft: assert property (
      $rose(s_r.ctrl.overflow_flag_high) |-> $past(ovf_h))
      else $error("high flag rose without overflow");

   a_low_hold_off: assert property (
      (!s_r.ctrl.count_enable_low && s_r.ctrl.count_reset_ctrl_low) |=> $stable(s_r.cnt_l))
      else $error("low counter moved while disabled");

   a_high_clear_ctl: assert property (
      (!s_r.ctrl.count_reset_ctrl_high && !standby) |=> s_r.cnt_h == AEC_CNT_RST)
      else $error("high counter not cleared by reset control");

   a_standby_hold: assert property (
      standby |=> $stable(s_r.cnt_h) && $stable(s_r.cnt_l))
      else $error("counters moved in standby");

   a_low_wrap_zero: assert property (
      ovf_l |=> s_r.cnt_l == AEC_CNT_RST)
      else $error("low counter did not wrap to zero");

   a_bus_answer: assert property (
      (bus_acc && av_rsp_o.waitrequest) |=> !av_rsp_o.waitrequest)
      else $error("bus access not answered in one cycle");

   a_reserved_store: assert property (
      wr_ctrl |=> s_r.ctrl.rsv == $past(av_req_i.writedata[5]))
      else $error("reserved bit not stored");

   a_split_high: assert property (
      (s_r.ctrl.ch2 && edge_h && s_r.ctrl.count_enable_high && s_r.ctrl.count_reset_ctrl_high
       && !standby) |=> s_r.cnt_h == $past(s_r.cnt_h) + AEC_CNT_ONE)
      else $error("high pin event not counted in split mode");

   // ************************************************************
   // assertions on counting, flags and the register bus
   // ************************************************************
   // counter gating, clearing and wrap
   a_low_clear_ctl: assert property (
      (!s_r.ctrl.count_reset_ctrl_low && !standby) |=> s_r.cnt_l == AEC_CNT_RST)
      else $error("low counter not cleared by reset control");

   a_high_hold_off: assert property (
      (!s_r.ctrl.count_enable_high && s_r.ctrl.count_reset_ctrl_high) |=> $stable(s_r.cnt_h))
      else $error("high counter moved while disabled");

   a_low_own_pin: assert property (
      (edge_l && s_r.ctrl.count_enable_low && s_r.ctrl.count_reset_ctrl_low && !standby)
       |=> s_r.cnt_l == $past(s_r.cnt_l) + AEC_CNT_ONE)
      else $error("low pin event not counted");

   a_high_wrap_zero: assert property (
      ovf_h |=> s_r.cnt_h == AEC_CNT_RST)
      else $error("high counter did not wrap to zero");

   a_chain_source: assert property (
      (!s_r.ctrl.ch2 && !ovf_l && s_r.ctrl.count_reset_ctrl_high) |=> $stable(s_r.cnt_h))
      else $error("high counter moved without a low carry");

   a_split_no_carry: assert property (
      (s_r.ctrl.ch2 && !edge_h && s_r.ctrl.count_reset_ctrl_high) |=> $stable(s_r.cnt_h))
      else $error("high counter moved without a high pin event");

   a_standby_ctrl: assert property (
      (standby && !wr_ctrl) |=> $stable(s_r.ctrl))
      else $error("control changed in standby without a write");

   // overflow flags and the request flag
   a_low_flag_set: assert property (
      ovl_set |=> s_r.ctrl.overflow_flag_low && s_r.irq_flag)
      else $error("low overflow did not set its flag");

   a_arm_on_read: assert property (
      (s_r.phase == AEC_BUS_IDLE && av_req_i.read && rd_sel == AEC_SEL_CTRL)
       |=> s_r.arm_h == $past(s_r.ctrl.overflow_flag_high))
      else $error("control read did not arm the high flag clear");

   a_arm_needed: assert property (
      (wr_ctrl && !s_r.arm_h && !ovf_h)
       |=> s_r.ctrl.overflow_flag_high == $past(s_r.ctrl.overflow_flag_high))
      else $error("high flag cleared without a read of one");

   a_armed_clear: assert property (
      (clr_h && !ovf_h) |=> !s_r.ctrl.overflow_flag_high)
      else $error("armed zero write did not clear the high flag");

   a_irq_sticky: assert property (
      (s_r.irq_flag && !irq_flag_clear_i) |=> s_r.irq_flag)
      else $error("request flag dropped without a clear");

   a_irq_clear: assert property (
      (irq_flag_clear_i && !ovf_h && !ovl_set) |=> !s_r.irq_flag)
      else $error("request flag not cleared");

   // register bus: stores and read data
   a_split_store: assert property (
      wr_ctrl |=> s_r.ctrl.ch2 == $past(av_req_i.writedata[4]))
      else $error("split select not stored");

   a_stop_store: assert property (
      wr_ckstp |=> s_r.ckstp == $past(av_req_i.writedata[3:0]))
      else $error("clock stop bits not stored");

   a_counter_ro: assert property (
      (av_req_i.write && s_r.phase == AEC_BUS_ANSWER
       && wr_sel == AEC_SEL_HIGH && s_r.ctrl.count_reset_ctrl_high && !inc_h)
       |=> $stable(s_r.cnt_h))
      else $error("high counter changed by a bus write");

   a_read_ctrl: assert property (
      (s_r.phase == AEC_BUS_IDLE && av_req_i.read && rd_sel == AEC_SEL_CTRL)
       |=> av_rsp_o.readdata == {AEC_RD_PAD, $past(s_r.ctrl)})
      else $error("control read data wrong");

   a_read_high: assert property (
      (s_r.phase == AEC_BUS_IDLE && av_req_i.read && rd_sel == AEC_SEL_HIGH)
       |=> av_rsp_o.readdata == {AEC_RD_PAD, $past(s_r.cnt_h)})
      else $error("high counter read data wrong");

   a_read_low: assert property (
      (s_r.phase == AEC_BUS_IDLE && av_req_i.read && rd_sel == AEC_SEL_LOW)
       |=> av_rsp_o.readdata == {AEC_RD_PAD, $past(s_r.cnt_l)})
      else $error("low counter read data wrong");

   a_read_none: assert property (
      (s_r.phase == AEC_BUS_IDLE && av_req_i.read && rd_sel == AEC_SEL_NONE)
       |=> av_rsp_o.readdata == AEC_RD_NONE)
      else $error("unmapped read data not zero");

   c_chain_wrap:  cover property (!s_r.ctrl.ch2 && ovf_h);
   c_split_low:   cover property (ovl_set);
   c_flag_clear:  cover property (clr_h ##1 !s_r.ctrl.overflow_flag_high);
   c_standby_use: cover property (standby && edge_l);
   c_chain_carry: cover property (!s_r.ctrl.ch2 && ovf_l && !ovf_h);

endmodule

`default_nettype wire

// ---- tb/aec_event_source.sv ----
// event source model standing on the far side of the two counter pins
`timescale 1ns/100ps
`default_nettype none

module aec_event_source (
   input  wire logic clk_sys_i,
   output logic      event_pin_high_o,
   output logic      event_pin_low_o
);
   // pins idle low, so no edge is seen when reset ends
   initial begin
      event_pin_high_o = 1'b0;
      event_pin_low_o  = 1'b0;
   end

   // one event: pin high one clock, then low for at least one clock
   // plus gap; a gap of zero is the fastest legal event rate
   task automatic pulse(input logic hi, input logic lo, input int gap);
      @(posedge clk_sys_i);
      event_pin_high_o <= hi;
      event_pin_low_o  <= lo;
      @(posedge clk_sys_i);
      event_pin_high_o <= 1'b0;
      event_pin_low_o  <= 1'b0;
      repeat (gap) @(posedge clk_sys_i);
   endtask
endmodule

`default_nettype wire

// ---- tb/aec_async_event_counter_test.sv ----
// self-checking bench of the event counter pair and its register slave
`timescale 1ns/100ps
`default_nettype none

module aec_async_event_counter_test;
   import aec_pkg::*;
   logic        clk_sys_i       = 1'b0;
   logic        rst_i           = 1'b1;
   aec_av_req_t av_req          = '0;
   aec_av_rsp_t av_rsp;
   logic        pin_h;
   logic        pin_l;
   logic        irq_en          = 1'b0;
   logic        irq_clr         = 1'b0;
   logic        irq_flag;
   logic        irq;
   logic [31:0] exp_q[$];
   logic [31:0] rng             = 32'h0001_5706;
   logic [7:0]  nl;
   logic [7:0]  nh;
   int          n_errors        = 0;
   int          samples_checked = 0;

   // ****************************************
   // clock, design and event source
   // ****************************************
   always #4 clk_sys_i = ~clk_sys_i;

   aec_async_event_counter DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .av_req_i(av_req), .av_rsp_o(av_rsp), .event_pin_high_i(pin_h),
      .event_pin_low_i(pin_l), .irq_enable_i(irq_en),
      .irq_flag_clear_i(irq_clr), .irq_flag_o(irq_flag), .irq_o(irq));
   aec_event_source src (.clk_sys_i(clk_sys_i), .event_pin_high_o(pin_h),
      .event_pin_low_o(pin_l));

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic chk_data(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_irq(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // one bus access; waitrequest is read at each rising edge before the
   // design's own updates land there, so the answering edge is exact
   task automatic av(input logic wr, input logic [AEC_AW-1:0] a,
                     input logic [7:0] d);
      int i;
      @(posedge clk_sys_i);
      av_req.read       <= ~wr;
      av_req.write      <= wr;
      av_req.address    <= a;
      av_req.byteenable <= 4'hf;
      av_req.writedata  <= {24'h00_0000, d};
      i = 0;
      do begin
         @(posedge clk_sys_i);
         i++;
      end while (av_rsp.waitrequest !== 1'b0 && i < 50);
      if (av_rsp.waitrequest !== 1'b0) begin
         n_errors++;
         $display("Error waitrequest expected 0 seen %b", av_rsp.waitrequest);
         tally_and_finish();
      end else begin
         av_req.read  <= 1'b0;
         av_req.write <= 1'b0;
      end
   endtask

   task automatic rd(input logic [AEC_AW-1:0] a, input logic [7:0] e);
      exp_q.push_back({24'h00_0000, e});
      av(1'b0, a, 8'h00);
   endtask

   task automatic ev(input logic hi, input logic lo, input int n);
      repeat (n) src.pulse(hi, lo, int'(rnd() % 3));
      repeat (3) @(posedge clk_sys_i);
   endtask

   // read monitor: oldest note against data standing at the answering edge
   always @(posedge clk_sys_i) begin
      if (av_req.read && av_rsp.waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("Error readdata expected none seen %h", av_rsp.readdata);
         end else begin
            chk_data("readdata", exp_q.pop_front(), av_rsp.readdata);
         end
      end
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      rd(AEC_ADDR_CTRL, 8'h00);
      rd(AEC_ADDR_HIGH, 8'h00);
      rd(AEC_ADDR_LOW, 8'h00);
      rd(AEC_ADDR_CKSTP, 8'hff);
      rd(18'h0_0010, 8'h00);
      wr_ctrl_checks();
      $display("test reset and access done");
      nl = 8'(1 + rnd() % 9);
      nh = 8'(1 + rnd() % 9);
      ev(1'b0, 1'b1, nl);
      ev(1'b1, 1'b0, nh);
      ev(1'b1, 1'b1, 2);
      rd(AEC_ADDR_LOW, nl + 8'h02);
      rd(AEC_ADDR_HIGH, nh + 8'h02);
      av(1'b1, AEC_ADDR_CTRL, 8'h17);
      ev(1'b1, 1'b1, 3);
      rd(AEC_ADDR_HIGH, nh + 8'h02);
      av(1'b1, AEC_ADDR_CTRL, 8'h1b);
      ev(1'b1, 1'b1, 2);
      rd(AEC_ADDR_LOW, nl + 8'h05);
      av(1'b1, AEC_ADDR_CTRL, 8'h1c);
      ev(1'b1, 1'b1, 2);
      rd(AEC_ADDR_HIGH, 8'h00);
      rd(AEC_ADDR_LOW, 8'h00);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      av(1'b1, AEC_ADDR_CKSTP, 8'hf7);
      rd(AEC_ADDR_CKSTP, 8'hf7);
      ev(1'b1, 1'b1, 4);
      rd(AEC_ADDR_LOW, 8'h00);
      av(1'b1, AEC_ADDR_CKSTP, 8'hff);
      $display("test split, gating, run and standby done");
      irq_en <= rnd() % 2 == 1;
      ev(1'b0, 1'b1, 256);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      rd(AEC_ADDR_LOW, 8'h00);
      rd(AEC_ADDR_CTRL, 8'h5f);
      @(negedge clk_sys_i);
      chk_irq("irq_flag", 1'b1, irq_flag);
      chk_irq("irq", irq_en, irq);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      rd(AEC_ADDR_CTRL, 8'h1f);
      @(posedge clk_sys_i);
      irq_clr <= 1'b1;
      @(posedge clk_sys_i);
      irq_clr <= 1'b0;
      @(negedge clk_sys_i);
      chk_irq("irq_flag", 1'b0, irq_flag);
      ev(1'b1, 1'b0, 256);
      rd(AEC_ADDR_HIGH, 8'h00);
      rd(AEC_ADDR_CTRL, 8'h9f);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      $display("test split overflow and clearing done");
      av(1'b1, AEC_ADDR_CTRL, 8'h0f);
      ev(1'b0, 1'b1, 256);
      rd(AEC_ADDR_HIGH, 8'h01);
      rd(AEC_ADDR_CTRL, 8'h0f);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      ev(1'b1, 1'b0, 254);
      av(1'b1, AEC_ADDR_CTRL, 8'h0f);
      ev(1'b0, 1'b1, 256);
      rd(AEC_ADDR_HIGH, 8'h00);
      rd(AEC_ADDR_CTRL, 8'h8f);
      $display("test chained carry and wrap done");
      tally_and_finish();
   end

   // flags never set by software, reserved bit kept, high counter read-only
   task automatic wr_ctrl_checks();
      av(1'b1, AEC_ADDR_CTRL, 8'hff);
      rd(AEC_ADDR_CTRL, 8'h3f);
      av(1'b1, AEC_ADDR_CTRL, 8'h1f);
      rd(AEC_ADDR_CTRL, 8'h1f);
      av(1'b1, AEC_ADDR_HIGH, 8'h5a);
      rd(AEC_ADDR_HIGH, 8'h00);
   endtask
endmodule

`default_nettype wire
